// ### hw/acs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// converter sequencer with AXI4-Lite register slave
module acs_sequencer #(
  parameter int NPINS = 13
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // write address channel
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // write data channel
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // write response channel
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // read address channel
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // read data channel
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // converter analog front end
  input  wire logic              rc_clk_tick,
  input  wire logic [9:0]        sar_value,
  input  wire logic [NPINS-1:0]  port_pins,
  output logic                   sample_enable,
  output logic                   cal_sample,
  output logic [3:0]             channel_select,
  // compare trigger and timer
  input  wire logic              special_trigger,
  output logic                   timer_clear,
  // status
  output logic                   conversion_done_flag
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0]        result_high;
  logic [7:0]        result_low;
  logic              calibrate_request;
  logic              start_flag;
  logic              converter_on;
  logic [1:0]        ref_cfg;
  logic [3:0]        port_analog_cfg;
  logic              result_justify;
  logic [2:0]        acquisition_time_sel;
  logic [2:0]        conversion_clock_sel;
  logic [3:0]        compare_mode_field;
  logic [9:0]        offset;
  logic              cal_run;
  logic [3:0]        chs_reg;
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [NPINS-1:0]  pins_s1;
  logic [NPINS-1:0]  pins_s2;
  logic [2:0]        trig_s;
  logic [1:0]        rc_s;
  logic              rc_prev;
  logic              trig_evt;
  logic              rc_evt;

  // two-stage synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_s1 <= '0;
      pins_s2 <= '0;
      trig_s  <= '0;
      rc_s    <= '0;
      rc_prev <= 1'b0;
    end else begin
      pins_s1 <= port_pins;
      pins_s2 <= pins_s1;
      trig_s  <= {trig_s[1:0], special_trigger};
      rc_s    <= {rc_s[0], rc_clk_tick};
      rc_prev <= rc_s[1];
    end
  end
  assign trig_evt = trig_s[1] && !trig_s[2];
  assign rc_evt   = rc_s[1] && !rc_prev;

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  logic              do_read;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= acs_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr > acs_pkg::ADDR_COMPARE || aw_addr[1:0] != 2'h0)
                      ? acs_pkg::RESP_SLVERR : acs_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_c0;
  logic wr_byte;
  assign wr_byte = do_write && w_strb[0];
  assign wr_c0   = wr_byte && aw_addr == acs_pkg::ADDR_CONTROL0;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  acs_pkg::acs_state_t state;
  logic [4:0]        tad_count;
  logic [1:0]        instr_count;
  logic              tad_tick;
  logic              sw_abort;
  logic              trig_start;
  logic              conv_end;
  logic              start_req;
  logic [9:0]        corrected;

  assign trig_start = trig_evt && converter_on &&
                      compare_mode_field == acs_pkg::MODE_SPECIAL; // RQ8 RQ10
  assign sw_abort   = wr_c0 && !w_data[acs_pkg::BIT_START] &&
                      state != acs_pkg::ACS_SAMPLE && state != acs_pkg::ACS_WAIT;
  assign conv_end   = state == acs_pkg::ACS_CONV && tad_tick &&
                      tad_count == 5'(acs_pkg::CONV_PERIODS - 1);
  assign start_req  = start_flag && converter_on;
  assign corrected  = (sar_value > offset) ? sar_value - offset : 10'h000; // RQ11

  acs_tad_gen u_tad (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .run                  (state != acs_pkg::ACS_SAMPLE && state != acs_pkg::ACS_DELAY),
    .conversion_clock_sel (conversion_clock_sel),
    .rc_tick              (rc_evt),
    .tad_tick             (tad_tick)
  );

  // state machine
  always_ff @(posedge aclk) begin
    if (!aresetn || !converter_on) begin
      state       <= acs_pkg::ACS_SAMPLE;
      tad_count   <= '0;
      instr_count <= '0;
    end else if (sw_abort) begin
      state     <= acs_pkg::ACS_WAIT; // RQ4
      tad_count <= '0;
    end else begin
      unique case (state)
        acs_pkg::ACS_SAMPLE: begin
          tad_count   <= '0;
          instr_count <= '0;
          if (start_req) begin
            if (acquisition_time_sel == acs_pkg::ACQ_NONE)
              state <= acs_pkg::ACS_DELAY; // RQ2
            else
              state <= acs_pkg::ACS_ACQ; // RQ3 RQ19
          end
        end
        acs_pkg::ACS_DELAY: begin
          instr_count <= instr_count + 2'h1;
          if (instr_count == 2'(acs_pkg::INSTR_CYCLES - 1))
            state <= acs_pkg::ACS_CONV; // RQ2
        end
        acs_pkg::ACS_ACQ: begin
          if (tad_tick) begin
            if (tad_count == acs_pkg::acq_periods(acquisition_time_sel) - 5'h01) begin
              state     <= acs_pkg::ACS_CONV; // RQ19
              tad_count <= '0;
            end else begin
              tad_count <= tad_count + 5'h01;
            end
          end
        end
        acs_pkg::ACS_CONV: begin
          if (tad_tick) begin
            if (conv_end) begin
              state     <= acs_pkg::ACS_WAIT; // RQ17
              tad_count <= '0;
            end else begin
              tad_count <= tad_count + 5'h01;
            end
          end
        end
        acs_pkg::ACS_WAIT: begin
          if (tad_tick) begin
            if (tad_count == 5'(acs_pkg::POST_WAIT - 1)) begin
              state     <= acs_pkg::ACS_SAMPLE; // RQ6
              tad_count <= '0;
            end else begin
              tad_count <= tad_count + 5'h01;
            end
          end
        end
      endcase
    end
  end

  // front-end controls
  assign sample_enable  = state == acs_pkg::ACS_SAMPLE || state == acs_pkg::ACS_ACQ ||
                          state == acs_pkg::ACS_DELAY; // RQ6
  assign cal_sample     = cal_run && state == acs_pkg::ACS_CONV; // RQ11
  assign channel_select = cal_run ? 4'h0 : chs_reg;
  assign timer_clear    = trig_evt; // RQ9 RQ10

  // control register zero with start flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      calibrate_request <= 1'b0;
      chs_reg           <= '0;
      start_flag        <= 1'b0;
      converter_on      <= 1'b0;
      cal_run           <= 1'b0;
    end else begin
      if (wr_c0) begin
        calibrate_request <= w_data[acs_pkg::BIT_CAL]; // RQ11
        chs_reg           <= w_data[acs_pkg::CHS_LSB +: 4];
        converter_on      <= w_data[acs_pkg::BIT_ON];
        // start only honoured once already enabled
        start_flag        <= w_data[acs_pkg::BIT_START] && converter_on;
      end
      if (state == acs_pkg::ACS_SAMPLE && start_req && calibrate_request) begin
        cal_run           <= 1'b1; // RQ11
        calibrate_request <= 1'b0;
      end
      if (conv_end || sw_abort) cal_run <= 1'b0;
      if (conv_end && !trig_start) start_flag <= 1'b0; // RQ18
      if (trig_start) start_flag <= 1'b1; // RQ8
    end
  end

  // other control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_cfg              <= '0;
      port_analog_cfg      <= acs_pkg::PCFG_RESET;
      result_justify       <= 1'b0;
      acquisition_time_sel <= '0;
      conversion_clock_sel <= '0;
      compare_mode_field   <= '0;
    end else if (wr_byte) begin
      if (aw_addr == acs_pkg::ADDR_CONTROL1) begin
        ref_cfg         <= w_data[5:4];
        port_analog_cfg <= w_data[3:0];
      end
      if (aw_addr == acs_pkg::ADDR_CONTROL2) begin
        result_justify       <= w_data[acs_pkg::BIT_JUSTIFY];
        acquisition_time_sel <= w_data[acs_pkg::ACQ_LSB +: 3];
        conversion_clock_sel <= w_data[2:0];
      end
      if (aw_addr == acs_pkg::ADDR_COMPARE) compare_mode_field <= w_data[3:0];
    end
  end

  // result pair, offset and done flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_high          <= '0;
      result_low           <= '0;
      offset               <= '0;
      conversion_done_flag <= 1'b0;
    end else begin
      if (wr_byte && aw_addr == acs_pkg::ADDR_RESULT_HIGH) result_high <= w_data[7:0];
      if (wr_byte && aw_addr == acs_pkg::ADDR_RESULT_LOW)  result_low  <= w_data[7:0];
      if (wr_byte && aw_addr == acs_pkg::ADDR_STATUS && w_data[acs_pkg::BIT_DONE])
        conversion_done_flag <= 1'b0;
      // an aborted conversion reaches here only when the abort write lands in the same cycle as conv_end
      if (conv_end) begin // RQ5
        conversion_done_flag <= 1'b1; // RQ18
        if (cal_run) begin
          offset <= sar_value; // RQ11
        end else if (result_justify) begin
          result_high <= {6'h00, corrected[9:8]}; // RQ18
          result_low  <= corrected[7:0];
        end else begin
          result_high <= corrected[9:2];
          result_low  <= {corrected[1:0], 6'h00};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [NPINS-1:0] analog_mask;
  always_comb begin
    analog_mask = '0;
    for (int i = 0; i < NPINS; i++)
      analog_mask[i] = i < 15 - int'(port_analog_cfg); // RQ1
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= acs_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= acs_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        acs_pkg::ADDR_RESULT_HIGH: s_axi_rdata <= {24'h0, result_high};
        acs_pkg::ADDR_RESULT_LOW:  s_axi_rdata <= {24'h0, result_low};
        acs_pkg::ADDR_CONTROL0:    s_axi_rdata <= {24'h0, calibrate_request, 1'b0, chs_reg,
                                                   start_flag, converter_on};
        acs_pkg::ADDR_CONTROL1:    s_axi_rdata <= {26'h0, ref_cfg, port_analog_cfg};
        acs_pkg::ADDR_CONTROL2:    s_axi_rdata <= {24'h0, result_justify, 1'b0,
                                                   acquisition_time_sel, conversion_clock_sel};
        acs_pkg::ADDR_STATUS:      s_axi_rdata <= {31'h0, conversion_done_flag};
        acs_pkg::ADDR_PORT:        s_axi_rdata <= 32'(pins_s2 & ~analog_mask); // RQ1
        acs_pkg::ADDR_COMPARE:     s_axi_rdata <= {28'h0, compare_mode_field};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= acs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // acs_sequencer
`default_nettype wire

// ### hw/acs_pkg.sv
// Behaviour
// RQ1 - analog-configured port pins read as low
// RQ2 - zero acquisition delays start one instruction cycle
// RQ3 - setting 010 samples four bit periods first
// RQ4 - clearing start flag aborts conversion at once
// RQ5 - abort leaves result registers unchanged; code still loads them when the abort write lands in the same cycle as conv_end
// RQ6 - two bit periods wait, then acquisition resumes
// RQ7 - software enables converter before requesting conversion
// RQ8 - compare mode 1011 trigger sets start flag
// RQ9 - every trigger clears the timer counter
// RQ10 - disabled converter ignores triggers, timer still cleared
// RQ11 - calibration conversion stores offset, later results subtract
// RQ12 - software recalibrates after reset or condition change
// RQ13 - sleep conversion needs internal RC clock
// RQ14 - software clears idle and clock selects first
// RQ15 - slow power-managed clock: choose RC source
// RQ16 - keep clock source until conversion ends
// RQ17 - conversion lasts eleven bit periods
// RQ18 - completion loads result, clears start, sets done
// RQ19 - nonzero setting samples programmed periods then converts
// RQ20 - bit period from divided clock or RC clock
package acs_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h00;
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h04;
  localparam logic [7:0] ADDR_CONTROL0    = 8'h08;
  localparam logic [7:0] ADDR_CONTROL1    = 8'h0C;
  localparam logic [7:0] ADDR_CONTROL2    = 8'h10;
  localparam logic [7:0] ADDR_STATUS      = 8'h14;
  localparam logic [7:0] ADDR_PORT        = 8'h18;
  localparam logic [7:0] ADDR_COMPARE     = 8'h1C;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_CAL      = 7;
  localparam int BIT_START    = 1;
  localparam int BIT_ON       = 0;
  localparam int BIT_JUSTIFY  = 7;
  localparam int BIT_DONE     = 0;
  localparam int CHS_LSB      = 2;
  localparam int ACQ_LSB      = 3;
  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [3:0] PCFG_RESET     = 4'h0;
  localparam logic [3:0] MODE_SPECIAL   = 4'hB;
  localparam logic [2:0] ACQ_NONE       = 3'h0;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CONV_PERIODS   = 11;
  localparam int POST_WAIT      = 2;
  localparam int INSTR_CYCLES   = 4;
  localparam int DIV_WIDTH      = 7;
  typedef enum logic [2:0] {
    ACS_SAMPLE, ACS_DELAY, ACS_ACQ, ACS_CONV, ACS_WAIT
  } acs_state_t;
  // acquisition periods per code
  function automatic logic [4:0] acq_periods(input logic [2:0] sel);
    logic [4:0] r;
    r = 5'h00;
    unique case (sel)
      3'h0: r = 5'h00;
      3'h1: r = 5'h02;
      3'h2: r = 5'h04;
      3'h3: r = 5'h06;
      3'h4: r = 5'h08;
      3'h5: r = 5'h0C;
      3'h6: r = 5'h10;
      3'h7: r = 5'h14;
    endcase
    return r;
  endfunction
endpackage

// ### hw/acs_tad_gen.sv
`timescale 1ns/1ps
`default_nettype none
// bit-period tick generator
module acs_tad_gen #(
  parameter int DIV_W = acs_pkg::DIV_WIDTH
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // control
  input  wire logic       run,
  input  wire logic [2:0] conversion_clock_sel,
  input  wire logic       rc_tick,
  // tick output
  output logic            tad_tick
);
  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] ratio;
  logic             use_rc;

  // divider ratio per select code
  always_comb begin
    use_rc = (conversion_clock_sel[1:0] == 2'h3);
    unique case (conversion_clock_sel)
      3'h0: ratio = 7'h02;
      3'h4: ratio = 7'h04;
      3'h1: ratio = 7'h08;
      3'h5: ratio = 7'h10;
      3'h2: ratio = 7'h20;
      3'h6: ratio = 7'h40;
      default: ratio = 7'h02;
    endcase
  end

  // oscillator divider or RC clock tick
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count    <= '0;
      tad_tick <= 1'b0;
    end else if (use_rc) begin
      count    <= '0;
      tad_tick <= rc_tick; // RQ20
    end else if (count == ratio - 7'h01) begin
      count    <= '0;
      tad_tick <= 1'b1; // RQ20
    end else begin
      count    <= count + 7'h01;
      tad_tick <= 1'b0;
    end
  end
endmodule // acs_tad_gen
`default_nettype wire

// ### sim/acs_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// port checker for the sequencer
// ------------------------------
module acs_sequencer_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // converter side
  input wire logic        sample_enable,
  input wire logic        cal_sample,
  input wire logic [3:0]  channel_select,
  input wire logic        special_trigger,
  input wire logic        timer_clear,
  input wire logic        conversion_done_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // control zero written in one edge
  sequence s_wr0;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      s_axi_awaddr == acs_pkg::ADDR_CONTROL0;
  endsequence
  sequence s_go;
    s_wr0 ##0 (s_axi_wdata[1:0] == 2'b11 && sample_enable);
  endsequence
  sequence s_stop;
    s_wr0 ##0 (!s_axi_wdata[1] && !sample_enable);
  endsequence
  sequence s_settle;
    !sample_enable [*2] ##[1:300] sample_enable;
  endsequence
  // sequencing, trigger and bus response checks
  AST_DELAY: assert property (s_go |=> sample_enable [*3])
    else $error("no start delay");
  AST_ABORT: assert property (s_stop |-> ##[1:400] sample_enable)
    else $error("no resume after abort");
  AST_WAIT: assert property ($rose(conversion_done_flag) |-> s_settle)
    else $error("post-conversion wait wrong");
  AST_CONV: assert property ($fell(sample_enable) |-> (!$rose(conversion_done_flag)) [*8])
    else $error("conversion too short");
  AST_CAL: assert property (cal_sample |-> channel_select == 4'h0 && !sample_enable)
    else $error("calibration read a channel");
  AST_TRIG: assert property ($rose(special_trigger) |-> ##[1:4] timer_clear)
    else $error("timer not cleared");
  AST_CLR: assert property (timer_clear |=> !timer_clear)
    else $error("timer clear too long");
  AST_BRESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_RRESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule // acs_sequencer_chk
bind acs_sequencer acs_sequencer_chk u_chk (.*);
`default_nettype wire

// ### sim/acs_front_model.sv
`timescale 1ns/1ps
`default_nettype none
// analog front end and compare trigger source
module acs_front_model #(
  parameter logic [9:0] CAL_OFS = 10'h005
) (
  // clock and commands
  input  wire logic       aclk,
  input  wire logic       fire,
  input  wire logic [9:0] level,
  // converter side
  input  wire logic       cal_sample,
  input  wire logic [3:0] channel_select,
  output logic            rc_clk_tick,
  output logic [9:0]      sar_value,
  output logic [12:0]     port_pins,
  output logic            special_trigger
);
  logic [2:0] hold = 3'h0;
  // free-running rc oscillator, unrelated to aclk
  initial begin
    rc_clk_tick = 1'b0;
    forever #137 rc_clk_tick = ~rc_clk_tick;
  end
  // dummy conversion reads the internal offset during calibration, else level plus channel_select
  assign sar_value = cal_sample ? CAL_OFS : level + 10'(channel_select);
  assign port_pins = 13'h1FFF;
  // trigger level held four cycles per request
  always @(posedge aclk) begin
    if (fire) hold <= 3'h4;
    else if (hold != 3'h0) hold <= hold - 3'h1;
  end
  assign special_trigger = hold != 3'h0;
endmodule // acs_front_model
`default_nettype wire

// ### sim/adc_conversion_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_tb;
  // ------------------------------
  // signals
  // ------------------------------
  localparam logic [9:0] LVL = 10'h2C4;
  localparam logic [9:0] OFS = 10'h005;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, fire;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, rc_clk_tick, sample_enable, cal_sample;
  logic        special_trigger, timer_clear, conversion_done_flag;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [9:0]  sar_value;
  logic [12:0] port_pins;
  logic [3:0]  channel_select;
  logic        cal_seen = 1'b0;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, tc = 0;
  // design and front-end model
  acs_sequencer u_dut (
    .*, .s_axi_wstrb(4'h1)
  );
  acs_front_model #(.CAL_OFS(OFS)) u_fe (
    .*, .level(LVL)
  );
  // clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // cycle limit and event counters
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (timer_clear === 1'b1) tc <= tc + 1;
    if (cal_sample === 1'b1) cal_seen <= 1'b1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic results;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int n, input int lo, input int hi);
    chk(nm, 32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("write resp", {30'h0, s_axi_bresp}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk("read data", d, e);
    chk("read resp", {30'h0, r}, 32'h0);
  endtask
  task automatic wt(input int s, input logic lvl, output int n);
    n = 0;
    while ((s == 0 ? sample_enable : conversion_done_flag) !== lvl) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic conv(input logic [7:0] c2, input logic [3:0] k, output int na, nc, nw);
    wr(acs_pkg::ADDR_STATUS, 8'h01);
    wr(acs_pkg::ADDR_CONTROL2, c2);
    wr(acs_pkg::ADDR_CONTROL0, {2'b00, k, 2'b11});
    wt(0, 1'b0, na);
    wt(1, 1'b1, nc);
    wt(0, 1'b1, nw);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'h20, d, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, acs_pkg::RESP_SLVERR});
    chk("unmapped data", d, 32'h0);
    wr(acs_pkg::ADDR_RESULT_LOW, 8'hA5);
    rdc(acs_pkg::ADDR_RESULT_LOW, 32'hA5);
    rdc(acs_pkg::ADDR_PORT, 32'h0);
    wr(acs_pkg::ADDR_CONTROL0, 8'h03);
    repeat (30) @(posedge aclk);
    chk("sampling", {31'h0, sample_enable}, 32'h1);
    rdc(acs_pkg::ADDR_CONTROL0, 32'h1);
    wr(acs_pkg::ADDR_CONTROL1, 8'h0D);
    repeat (4) @(posedge aclk);
    rdc(acs_pkg::ADDR_PORT, 32'h1FFC);
    wr(acs_pkg::ADDR_CONTROL1, 8'h0F);
    repeat (4) @(posedge aclk);
    rdc(acs_pkg::ADDR_PORT, 32'h1FFF);
  endtask
  task automatic t_acq;
    int         p [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int         na, nc, nw;
    logic [9:0] v;
    for (int k = 0; k < 8; k++) begin
      v = LVL + 10'(k);
      conv(8'h80 | 8'(k << 3), 4'(k), na, nc, nw);
      rng("acquire", na, (p[k] == 0) ? 1 : 2 * p[k] - 3, 2 * p[k] + 6);
      rng("convert", nc, 19, 26);
      rng("settle", nw, 2, 8);
      rdc(acs_pkg::ADDR_RESULT_HIGH, {30'h0, v[9:8]});
      rdc(acs_pkg::ADDR_RESULT_LOW, {24'h0, v[7:0]});
      rdc(acs_pkg::ADDR_STATUS, 32'h1);
      rdc(acs_pkg::ADDR_CONTROL0, {26'h0, 4'(k), 2'b01});
    end
  endtask
  task automatic t_abort;
    int n;
    wr(acs_pkg::ADDR_STATUS, 8'h01);
    wr(acs_pkg::ADDR_CONTROL2, 8'h86);
    wr(acs_pkg::ADDR_CONTROL0, 8'h03);
    wt(0, 1'b0, n);
    repeat (40) @(posedge aclk);
    wr(acs_pkg::ADDR_CONTROL0, 8'h01);
    wt(0, 1'b1, n);
    rng("resume", n, 60, 140);
    chk("done", {31'h0, conversion_done_flag}, 32'h0);
    rdc(acs_pkg::ADDR_RESULT_HIGH, 32'h2);
    rdc(acs_pkg::ADDR_RESULT_LOW, 32'hCB);
  endtask
  task automatic t_trig;
    int n, t0;
    wr(acs_pkg::ADDR_CONTROL2, 8'h80);
    wr(acs_pkg::ADDR_COMPARE, {4'h0, acs_pkg::MODE_SPECIAL});
    wr(acs_pkg::ADDR_CONTROL0, 8'h00);
    t0 = tc;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (60) @(posedge aclk);
    chk("clears", 32'(tc - t0), 32'h1);
    chk("done", {31'h0, conversion_done_flag}, 32'h0);
    wr(acs_pkg::ADDR_CONTROL0, 8'h01);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    wt(1, 1'b1, n);
    chk("done", {31'h0, conversion_done_flag}, 32'h1);
    chk("clears", 32'(tc - t0), 32'h2);
    rdc(acs_pkg::ADDR_RESULT_LOW, {24'h0, LVL[7:0]});
    wt(0, 1'b1, n);
  endtask
  task automatic t_cal;
    int         n, nc;
    logic [9:0] v;
    v = LVL - OFS;
    wr(acs_pkg::ADDR_STATUS, 8'h01);
    wr(acs_pkg::ADDR_CONTROL0, 8'h81);
    wr(acs_pkg::ADDR_CONTROL0, 8'h83);
    wt(1, 1'b1, n);
    chk("calibrated", {31'h0, cal_seen}, 32'h1);
    wt(0, 1'b1, n);
    conv(8'h83, 4'h0, n, nc, n);
    rng("rc convert", nc, 60, 96);
    rdc(acs_pkg::ADDR_RESULT_HIGH, {30'h0, v[9:8]});
    rdc(acs_pkg::ADDR_RESULT_LOW, {24'h0, v[7:0]});
  endtask
  // main sequence
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    fire = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_acq();
    t_abort();
    t_trig();
    t_cal();
    results();
  end
endmodule // adc_conversion_sequencer_tb
`default_nettype wire
